/* common/dfrs_pkg.sv */
// Package of constants and types for the frequency reference selector
package dfrs_pkg;
	// ******************************************************************
	// Timing
	// ******************************************************************
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned HOLD_MIN_MS    = 50;
	localparam int unsigned HOLD_MIN_CYC   =
		(CLK_HZ / 1000) * HOLD_MIN_MS;
	localparam int unsigned TICK_US        = 1000;
	localparam int unsigned TICK_CYC       = (CLK_HZ / 1000000) * TICK_US;

	// ******************************************************************
	// Widths and codes
	// ******************************************************************
	localparam int FW = 16;                  // Frequency, 0.01 Hz units
	localparam int PW = 11;                  // Percent, 0.1 % units
	localparam int TW = 16;                  // Ramp time, 0.1 s units
	localparam logic [5:0] FN_HOLD2W  = 6'h35;  // 53
	localparam logic [5:0] FN_3WIRE   = 6'h1a;  // 26
	localparam logic [3:0] AI2_ADD    = 4'ha;   // 10
	localparam logic [3:0] AI2_AUX    = 4'h0;
	localparam logic [1:0] PI_FREQREF = 2'h0;
	localparam logic [FW-1:0] FREQ_MAX_CODE = 16'he9fc; // 599.00 Hz
	localparam logic [PW-1:0] PCT_FULL = 11'h3e8;       // 100.0 %
	localparam logic [PW-1:0] PCT_MAX  = 11'h442;       // 109.0 %
	localparam logic [PW-1:0] PCT_UMIN = 11'h001;       // 0.1 %
	localparam logic [TW-1:0] TIME_MIN = 16'h0001;      // 0.1 s
	localparam logic [TW-1:0] TIME_MAX = 16'hea60;      // 6000.0 s
	localparam logic [2:0] AI_TYPE_RST = 3'h1;
	localparam logic [FW-1:0] UPDN_STEP = 16'h0001;

	typedef enum logic [1:0] {RUN_KEYPAD, RUN_TERM, RUN_COMM, RUN_PLC}
		dfrs_run_e;
	typedef enum logic [2:0] {
		SRC_KEYPAD, SRC_ANALOG, SRC_UPDN, SRC_COMM,
		SRC_PULSE, SRC_RSV5, SRC_RSV6, SRC_AI2AUX
	} dfrs_src_e;

	// Run command from one source
	typedef struct packed {
		logic run;
		logic rev;
	} dfrs_cmd_s;

	// Sampled analog and pulse values, already scaled to 0.01 Hz except ai2Pct
	typedef struct packed {
		logic [FW-1:0] ai1;
		logic [FW-1:0] ai2;
		logic [FW-1:0] ai2Pct;  // AI2 as 0.1 % of full scale
		logic [FW-1:0] pulse;
	} dfrs_meas_s;

	// Setting errors
	typedef struct packed {
		logic holdConflict;
		logic sourceConflict;
		logic setRange;
	} dfrs_err_s;

	// Ramp set handed to the ramp generator
	typedef struct packed {
		logic [TW-1:0] accel;
		logic [TW-1:0] decel;
		logic [1:0]    setIdx;
	} dfrs_ramp_s;
endpackage : dfrs_pkg

/* hw/dfrs_select.sv */
// Run source, frequency reference and ramp set selection logic
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Code 53 on terminals three-eight enables hold mode
// - Hold inputs need 50 ms before acting
// - Codes 53 and 26 together raise hold conflict
// - Run source 2 serial, 3 built-in logic
// - Source codes decode keypad, analog, updown, comm, pulse
// - Analog source uses input one or two
// - Second input function 10 adds input two
// - Up raises, down lowers reference
// - Pulse function 0 uses scaled pulse frequency
// - Code 7 uses input two if function 0
// - Combine 0 main only, 1 main plus alternative
// - Combine with equal selectors raises source conflict
// - Keypad alternative uses speed-stage zero setting
// - Expose serial commanded frequency when comm selected
// - Retain flag saves serial frequency over power loss when comm selected
// - Sleep clamps PID to lower limit or zero
// - Upper limit percent of active motor maximum
// - Lower limit percent of active motor maximum
// - Start ramps from minimum up to lower limit
// - Upper below lower raises set-range error
// - Limits apply for every source
// - Four accel and four decel times
// - No terminal select: set four above switch-over
// - Two terminal bits pick ramp set
module dfrs_select
(
	input  wire logic                       mclk,
	input  wire logic                       srst,
	input  wire logic [7:0]                 termPins,
	input  wire logic [5:0]                 termFunc [8],
	input  wire dfrs_pkg::dfrs_run_e        runSrcSel,
	input  wire dfrs_pkg::dfrs_cmd_s        keypadCmd,
	input  wire dfrs_pkg::dfrs_cmd_s        commCmd,
	input  wire dfrs_pkg::dfrs_cmd_s        plcCmd,
	input  wire dfrs_pkg::dfrs_src_e        mainSrcSel,
	input  wire dfrs_pkg::dfrs_src_e        altSrcSel,
	input  wire logic                       combineMode,
	input  wire logic [2:0]                 aiSignalType,
	input  wire logic [3:0]                 ai2Function,
	input  wire logic [1:0]                 pulseFunction,
	input  wire dfrs_pkg::dfrs_meas_s       meas,
	input  wire logic [dfrs_pkg::FW-1:0]    keypadFreq,
	input  wire logic [dfrs_pkg::FW-1:0]    stage0Freq,
	input  wire logic                       commFreqWr,
	input  wire logic [dfrs_pkg::FW-1:0]    commFreqData,
	input  wire logic                       retainComm,
	input  wire logic [dfrs_pkg::FW-1:0]    commFreqSaved,
	input  wire logic                       termUp,
	input  wire logic                       termDown,
	input  wire logic                       upDownAssigned,
	input  wire logic                       sleeping,
	input  wire logic                       sleepLimitSel,
	input  wire logic [dfrs_pkg::FW-1:0]    pidOut,
	input  wire logic [dfrs_pkg::PW-1:0]    upperPct,
	input  wire logic [dfrs_pkg::PW-1:0]    lowerPct,
	input  wire logic                       motorTwo,
	input  wire logic [dfrs_pkg::FW-1:0]    maxFreqM1,
	input  wire logic [dfrs_pkg::FW-1:0]    maxFreqM2,
	input  wire logic [dfrs_pkg::FW-1:0]    minFreqM1,
	input  wire logic [dfrs_pkg::FW-1:0]    minFreqM2,
	input  wire logic                       starting,
	input  wire logic [dfrs_pkg::FW-1:0]    outFreq,
	input  wire logic [dfrs_pkg::FW-1:0]    switchOverFreq,
	input  wire logic [dfrs_pkg::TW-1:0]    accelTime [4],
	input  wire logic [dfrs_pkg::TW-1:0]    decelTime [4],
	input  wire logic                       rampSelBit1,
	input  wire logic                       rampSelBit2,
	input  wire logic                       rampSelUsed,
	output logic                            holdMode,
	output dfrs_pkg::dfrs_cmd_s             runCmd,
	output logic [2:0]                      aiTypeOut,
	output logic [dfrs_pkg::FW-1:0]         commFreqView,
	output logic                            commFreqViewValid,
	output logic                            commFreqSaveEn,
	output logic [dfrs_pkg::FW-1:0]         pidLimited,
	output logic [dfrs_pkg::FW-1:0]         targetFreq,
	output logic                            startFromMin,
	output logic [dfrs_pkg::FW-1:0]         startFreq,
	output dfrs_pkg::dfrs_ramp_s            ramp,
	output dfrs_pkg::dfrs_err_s             setErr
);
	import dfrs_pkg::*;

	// ******************************************************************
	// Functions
	// ******************************************************************
	// Percent of maximum (0.1 % units) to frequency
	function automatic logic [FW-1:0] pctOf(
		input logic [PW-1:0] pct,
		input logic [FW-1:0] fmax
	);
		logic [FW+PW-1:0] prod;
		prod = fmax * pct;
		pctOf = FW'(prod / (FW+PW)'(PCT_FULL));
	endfunction : pctOf

	// Saturating sum
	function automatic logic [FW-1:0] satAdd(
		input logic [FW-1:0] a,
		input logic [FW-1:0] b
	);
		logic [FW:0] s;
		s = {1'b0, a} + {1'b0, b};
		satAdd = s[FW] ? {FW{1'b1}} : s[FW-1:0];
	endfunction : satAdd

	// ******************************************************************
	// Input synchronisers and tick
	// ******************************************************************
	logic [7:0]  pinMeta_r;
	logic [7:0]  pinSync_r;
	logic [1:0]  updnMeta_r;
	logic [1:0]  updnSync_r;
	logic [13:0] tickCnt_r;
	logic        tick;

	// Two-stage sampling of terminal pins
	always_ff @(posedge mclk)
	begin
		pinMeta_r  <= termPins;
		pinSync_r  <= pinMeta_r;
		updnMeta_r <= {termDown, termUp};
		updnSync_r <= updnMeta_r;
	end

	// Control sample tick divider
	always_ff @(posedge mclk)
	begin
		if (srst || tick)
			tickCnt_r <= '0;
		else
			tickCnt_r <= tickCnt_r + 14'h0001;
	end
	assign tick = (tickCnt_r == 14'(TICK_CYC - 1));

	// ******************************************************************
	// Terminal modes and hold qualification
	// ******************************************************************
	logic [7:0] is53;
	logic [7:0] isHold;
	logic [7:0] is3w;
	logic       holdEn;
	logic       any3w;
	logic [2:0] qualIn;
	logic [2:0] qual_r;
	logic [19:0] holdCnt_r [3];

	// Per-terminal function decode
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_term
			assign is53[gi]   = (termFunc[gi] == FN_HOLD2W);
			assign isHold[gi] = (gi >= 2) && is53[gi];
			assign is3w[gi]   = (termFunc[gi] == FN_3WIRE);
		end
	endgenerate
	assign holdEn = |isHold;
	assign any3w  = |is3w;
	assign qualIn = {pinSync_r[4], pinSync_r[1], pinSync_r[0]};

	// 50 ms qualification of terminals one, two and five
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_qual
			always_ff @(posedge mclk)
			begin
				if (srst || !qualIn[gi])
				begin
					holdCnt_r[gi] <= '0;
					qual_r[gi]    <= 1'b0;
				end
				else if (holdCnt_r[gi] >= 20'(HOLD_MIN_CYC - 1))
					qual_r[gi] <= 1'b1;
				else
					holdCnt_r[gi] <= holdCnt_r[gi] + 20'h00001;
			end
		end
	endgenerate

	// ******************************************************************
	// Run command source
	// ******************************************************************
	dfrs_cmd_s termCmd;
	dfrs_cmd_s runNxt;
	logic      fwdIn;
	logic      revIn;

	// Hold mode uses qualified inputs, else raw synced inputs
	assign fwdIn = holdEn ? qual_r[0] : pinSync_r[0];
	assign revIn = holdEn ? qual_r[1] : pinSync_r[1];
	assign termCmd.run = fwdIn ^ revIn;
	assign termCmd.rev = revIn & ~fwdIn;
	assign runNxt = (runSrcSel == RUN_COMM) ? commCmd :
		(runSrcSel == RUN_PLC) ? plcCmd :
		(runSrcSel == RUN_TERM) ? termCmd : keypadCmd;

	// ******************************************************************
	// Serial frequency and up/down
	// ******************************************************************
	logic [FW-1:0] commFreq_r;
	logic [FW-1:0] updn_r;
	logic [FW-1:0] commClip;
	logic          commSel;

	assign commClip = (commFreqData > FREQ_MAX_CODE) ?
		FREQ_MAX_CODE : commFreqData;
	assign commSel = (mainSrcSel == SRC_COMM) || (altSrcSel == SRC_COMM);

	// Serial frequency, saved copy restored on reset when retained
	always_ff @(posedge mclk)
	begin
		if (srst)
			commFreq_r <= retainComm ? commFreqSaved : '0;
		else if (commFreqWr)
			commFreq_r <= commClip;
	end

	// Up/down reference accumulator, stepped each tick
	always_ff @(posedge mclk)
	begin
		if (srst)
			updn_r <= '0;
		else if (tick && upDownAssigned)
		begin
			if (updnSync_r[0] && !updnSync_r[1])
				updn_r <= satAdd(updn_r, UPDN_STEP);
			else if (updnSync_r[1] && !updnSync_r[0] && updn_r != '0)
				updn_r <= updn_r - UPDN_STEP;
		end
	end

	// ******************************************************************
	// Source decode and combine
	// ******************************************************************
	logic [FW-1:0] fmax;
	logic [FW-1:0] analogRef;
	logic [FW-1:0] ai2AuxRef;
	logic [FW-1:0] pulseRef;
	logic [FW-1:0] mainRef;
	logic [FW-1:0] altRef;
	logic [FW-1:0] sumRef;
	logic [FW-1:0] upLim;
	logic [FW-1:0] loLim;
	logic [FW-1:0] clampRef;
	logic [FW-1:0] updnRef;

	assign fmax = motorTwo ? maxFreqM2 : maxFreqM1;
	assign updnRef = upDownAssigned ? updn_r : '0;
	assign analogRef = (ai2Function == AI2_ADD) ?
		satAdd(meas.ai1, meas.ai2) : meas.ai1;
	assign ai2AuxRef = (ai2Function == AI2_AUX) ?
		pctOf(PW'(meas.ai2Pct), fmax) : '0;
	assign pulseRef = (pulseFunction == PI_FREQREF) ? meas.pulse : '0;

	// Reference for a given source code
	function automatic logic [FW-1:0] srcRef(
		input dfrs_src_e     sel,
		input logic [FW-1:0] keyVal, anaVal, udVal,
		input logic [FW-1:0] comVal, pulVal, auxVal
	);
		case (sel)
			SRC_KEYPAD:  srcRef = keyVal;
			SRC_ANALOG:  srcRef = anaVal;
			SRC_UPDN:    srcRef = udVal;
			SRC_COMM:    srcRef = comVal;
			SRC_PULSE:   srcRef = pulVal;
			SRC_AI2AUX:  srcRef = auxVal;
			default:     srcRef = '0;
		endcase
	endfunction : srcRef

	assign mainRef = srcRef(mainSrcSel, keypadFreq, analogRef, updnRef,
		commFreq_r, pulseRef, ai2AuxRef);
	assign altRef  = srcRef(altSrcSel, stage0Freq, analogRef,
		updnRef, commFreq_r, pulseRef, ai2AuxRef);
	assign sumRef  = combineMode ? satAdd(mainRef, altRef) : mainRef;

	// Limits for every source; if inverted, lower wins unless reference exceeds upper
	assign upLim = pctOf((upperPct > PCT_MAX) ? PCT_MAX :
		((upperPct < PCT_UMIN) ? PCT_UMIN : upperPct), fmax);
	assign loLim = pctOf((lowerPct > PCT_MAX) ? PCT_MAX : lowerPct,
		fmax);
	assign clampRef = (sumRef > upLim) ? upLim :
		((sumRef < loLim) ? loLim : sumRef);

	// ******************************************************************
	// Ramp set selection
	// ******************************************************************
	logic [1:0] rampIdx;
	logic [TW-1:0] accClip;
	logic [TW-1:0] decClip;

	assign rampIdx = rampSelUsed ? {rampSelBit2, rampSelBit1} :
		((outFreq >= switchOverFreq) ? 2'h3 : 2'h0);
	assign accClip = (accelTime[rampIdx] < TIME_MIN) ? TIME_MIN :
		((accelTime[rampIdx] > TIME_MAX) ? TIME_MAX : accelTime[rampIdx]);
	assign decClip = (decelTime[rampIdx] < TIME_MIN) ? TIME_MIN :
		((decelTime[rampIdx] > TIME_MAX) ? TIME_MAX : decelTime[rampIdx]);

	// ******************************************************************
	// Output registers
	// ******************************************************************
	// Errors and decoded modes, evaluated every cycle
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			holdMode          <= 1'b0;
			runCmd            <= '0;
			setErr            <= '0;
			aiTypeOut         <= AI_TYPE_RST;
			commFreqView      <= '0;
			commFreqViewValid <= 1'b0;
			commFreqSaveEn    <= 1'b0;
		end
		else
		begin
			holdMode                 <= holdEn;
			runCmd                   <= runNxt;
			setErr.holdConflict      <= (|is53) && any3w;
			setErr.sourceConflict    <= combineMode &&
				(mainSrcSel == altSrcSel);
			setErr.setRange          <= upperPct < lowerPct;
			aiTypeOut                <= aiSignalType;
			commFreqView             <= commSel ? commFreq_r : '0;
			commFreqViewValid        <= commSel;
			commFreqSaveEn           <= commSel && retainComm;
		end
	end

	// Target, PID limit and ramp set, refreshed on tick
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			targetFreq   <= '0;
			pidLimited   <= '0;
			startFromMin <= 1'b0;
			startFreq    <= '0;
			ramp         <= '0;
		end
		else if (tick)
		begin
			targetFreq   <= clampRef;
			pidLimited   <= !sleeping ? pidOut :
				(sleepLimitSel ? '0 : loLim);
			startFromMin <= starting && (lowerPct != '0);
			startFreq    <= motorTwo ? minFreqM2 : minFreqM1;
			ramp.accel   <= accClip;
			ramp.decel   <= decClip;
			ramp.setIdx  <= rampIdx;
		end
	end

endmodule : dfrs_select

`default_nettype wire

/* verification/dfrs_far_model.sv */
// Far-side model: terminal strip and serial master
`timescale 1ns/1ns
`default_nettype none
module dfrs_far_model
(
	input  wire logic                 mclk,
	output var logic [7:0]            termPins,
	output var logic                  commFreqWr,
	output var logic [dfrs_pkg::FW-1:0] commFreqData
);
	import dfrs_pkg::*;

	// Idle terminals open, serial line quiet
	initial
	begin
		termPins = 8'h00;
		commFreqWr = 1'b0;
		commFreqData = 16'h5a5a;
	end

	// Close one terminal for a count of cycles
	task automatic press(input int idx, input int n);
		termPins[idx] <= 1'b1;
		repeat (n) @(posedge mclk);
		termPins[idx] <= 1'b0;
	endtask : press

	// One frequency write, data scrambled once released
	task automatic mbWrite(input logic [FW-1:0] d);
		commFreqWr <= 1'b1;
		commFreqData <= d;
		@(posedge mclk);
		commFreqWr <= 1'b0;
		commFreqData <= ~d;
	endtask : mbWrite
endmodule : dfrs_far_model
`default_nettype wire

/* verification/dfrs_select_sva.sv */
// Checker of mode and setting-error outputs
`timescale 1ns/1ns
`default_nettype none
module dfrs_select_sva
(
	input wire logic                 mclk,
	input wire logic                 srst,
	input wire logic [5:0]           termFunc [8],
	input wire dfrs_pkg::dfrs_run_e  runSrcSel,
	input wire dfrs_pkg::dfrs_cmd_s  commCmd,
	input wire dfrs_pkg::dfrs_cmd_s  plcCmd,
	input wire dfrs_pkg::dfrs_src_e  mainSrcSel,
	input wire dfrs_pkg::dfrs_src_e  altSrcSel,
	input wire logic                 combineMode,
	input wire logic [2:0]           aiSignalType,
	input wire logic [dfrs_pkg::PW-1:0] upperPct,
	input wire logic [dfrs_pkg::PW-1:0] lowerPct,
	input wire logic                 retainComm,
	input wire logic                 holdMode,
	input wire dfrs_pkg::dfrs_cmd_s  runCmd,
	input wire logic [2:0]           aiTypeOut,
	input wire logic                 commFreqViewValid,
	input wire logic                 commFreqSaveEn,
	input wire dfrs_pkg::dfrs_err_s  setErr
);
	import dfrs_pkg::*;

	logic [7:0] is53;
	logic [7:0] is26;
	logic       commSel;

	// Code matches per terminal
	for (genvar i = 0; i < 8; i++)
	begin : g_code
		assign is53[i] = termFunc[i] == FN_HOLD2W;
		assign is26[i] = termFunc[i] == FN_3WIRE;
	end
	assign commSel = mainSrcSel == SRC_COMM || altSrcSel == SRC_COMM;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	// Mode and error relations
	hold_mode_a: assert property (1'b1 |=> holdMode == $past(|is53[7:2]))
		else $error("hold mode mismatch");
	hold_conflict_a: assert property ((|is53 && |is26) |=> setErr.holdConflict)
		else $error("hold conflict missing");
	source_conflict_a: assert property (combineMode && mainSrcSel == altSrcSel
		|=> setErr.sourceConflict) else $error("source conflict missing");
	no_conflict_a: assert property (!combineMode |=> !setErr.sourceConflict)
		else $error("source conflict without combine");
	set_range_a: assert property (1'b1 |=> setErr.setRange == $past(upperPct < lowerPct))
		else $error("set range mismatch");
	comm_view_a: assert property (commSel [*2] |-> commFreqViewValid)
		else $error("comm view not valid");
	comm_save_a: assert property (1'b1 |=>
		commFreqSaveEn == $past(retainComm && commSel)) else $error("save flag");
	run_serial_a: assert property (runSrcSel == RUN_COMM |=> runCmd == $past(commCmd))
		else $error("serial run mismatch");
	run_plc_a: assert property (runSrcSel == RUN_PLC |=> runCmd == $past(plcCmd))
		else $error("plc run mismatch");
	ai_type_a: assert property ($changed(aiSignalType) |=> aiTypeOut == $past(aiSignalType))
		else $error("signal type mismatch");

	// Main scenarios reached
	hold_c: cover property (setErr.holdConflict);
	src_c: cover property (setErr.sourceConflict);
	view_c: cover property (commFreqViewValid);
endmodule : dfrs_select_sva

bind dfrs_select dfrs_select_sva chk_i (.mclk, .srst, .termFunc, .runSrcSel,
	.commCmd, .plcCmd, .mainSrcSel, .altSrcSel, .combineMode, .aiSignalType,
	.upperPct, .lowerPct, .retainComm, .holdMode, .runCmd, .aiTypeOut,
	.commFreqViewValid, .commFreqSaveEn, .setErr);
`default_nettype wire

/* verification/dfrs_select_tb_top.sv */
// Testbench of the frequency reference selector
`timescale 1ns/1ns
`default_nettype none
module dfrs_select_tb_top;
	import dfrs_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	wire logic [7:0] termPins;
	wire logic commFreqWr;
	wire logic [FW-1:0] commFreqData;
	logic [5:0] termFunc [8];
	dfrs_run_e runSrcSel;
	dfrs_cmd_s keypadCmd, commCmd, plcCmd, runCmd;
	dfrs_src_e mainSrcSel, altSrcSel;
	logic combineMode, retainComm, termUp, termDown, upDownAssigned;
	logic sleeping, sleepLimitSel, motorTwo, starting, rampSelBit1;
	logic rampSelBit2, rampSelUsed, holdMode, commFreqViewValid;
	logic commFreqSaveEn, startFromMin;
	logic [2:0] aiSignalType, aiTypeOut;
	logic [3:0] ai2Function;
	logic [1:0] pulseFunction;
	dfrs_meas_s meas;
	logic [FW-1:0] keypadFreq, stage0Freq, commFreqSaved, pidOut, maxFreqM1;
	logic [FW-1:0] maxFreqM2, minFreqM1, minFreqM2, outFreq, switchOverFreq;
	logic [FW-1:0] commFreqView, pidLimited, targetFreq, startFreq, t0;
	logic [PW-1:0] upperPct, lowerPct;
	logic [TW-1:0] accelTime [4], decelTime [4];
	dfrs_ramp_s ramp;
	dfrs_err_s setErr;
	int err_count = 0;
	int num_checks = 0;

	// Clock and units
	always #50 mclk = ~mclk;
	dfrs_select uut (.*);
	dfrs_far_model far (.mclk, .termPins, .commFreqWr, .commFreqData);

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic tick();
		cyc(TICK_CYC + 8);
	endtask : tick
	task automatic chkRamp(input int k);
		chk("setIdx", ramp.setIdx, k);
		chk("accel", ramp.accel, accelTime[k]);
		chk("decel", ramp.decel, decelTime[k]);
	endtask : chkRamp
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// Main sequence
	initial
	begin
		foreach (termFunc[i]) termFunc[i] = 6'h00;
		foreach (accelTime[i]) accelTime[i] = 16'(10 * (i + 1));
		foreach (decelTime[i]) decelTime[i] = 16'(100 * (i + 1));
		runSrcSel = RUN_KEYPAD;
		{keypadCmd, commCmd, plcCmd} = '0;
		mainSrcSel = SRC_KEYPAD;
		altSrcSel = SRC_KEYPAD;
		{combineMode, retainComm, termUp} = '0;
		{termDown, upDownAssigned, sleeping, sleepLimitSel, motorTwo} = '0;
		{starting, rampSelBit1, rampSelBit2, rampSelUsed} = '0;
		{aiSignalType, ai2Function, pulseFunction, meas} = '0;
		{keypadFreq, stage0Freq, commFreqSaved, pidOut, outFreq} = '0;
		{maxFreqM1, maxFreqM2, minFreqM1, minFreqM2} = {16'h1770, 16'h1f40, 16'h0064, 16'h0096};
		{switchOverFreq, upperPct, lowerPct} = {16'h0bb8, PCT_MAX, 11'h000};
		aiSignalType = AI_TYPE_RST;
		cyc(3);
		srst <= 1'b0;
		cyc(2);
		chk("aiTypeRst", aiTypeOut, AI_TYPE_RST);
		chk("holdRst", holdMode, 0);
		aiSignalType <= 3'h5;
		termFunc[2] <= FN_HOLD2W;
		termFunc[5] <= FN_3WIRE;
		cyc(2);
		chk("aiType", aiTypeOut, 3'h5);
		chk("holdMode", holdMode, 1);
		chk("holdConflict", setErr.holdConflict, 1);
		termFunc[5] <= 6'h00;
		commCmd <= 2'b10;
		plcCmd <= 2'b01;
		runSrcSel <= RUN_COMM;
		cyc(2);
		chk("holdClear", setErr.holdConflict, 0);
		chk("runSerial", runCmd, 2'b10);
		runSrcSel <= RUN_PLC;
		cyc(2);
		chk("runPlc", runCmd, 2'b01);
		runSrcSel <= RUN_TERM;
		fork
			far.press(0, 1000);
		join_none
		cyc(990);
		chk("shortHold", runCmd.run, 0);
		cyc(20);
		termFunc[2] <= 6'h00;
		combineMode <= 1'b1;
		mainSrcSel <= SRC_PULSE;
		altSrcSel <= SRC_PULSE;
		{upperPct, lowerPct} <= {11'h12c, 11'h1f4};
		cyc(2);
		chk("srcConflict", setErr.sourceConflict, 1);
		chk("setRange", setErr.setRange, 1);
		$display("test modes and errors done");
		// Analog add plus keypad alternative
		mainSrcSel <= SRC_ANALOG;
		altSrcSel <= SRC_KEYPAD;
		ai2Function <= AI2_ADD;
		{meas.ai1, meas.ai2, stage0Freq, pidOut} <= {16'd1000, 16'd500, 16'd700, 16'd777};
		{upperPct, lowerPct, rampSelUsed, rampSelBit1} <= {PCT_MAX, 11'h000, 2'b11};
		tick();
		chk("sumRef", targetFreq, 1000 + 500 + 700);
		chk("pidAwake", pidLimited, 777);
		chkRamp(1);
		// Pulse source clamped by upper limit
		mainSrcSel <= SRC_PULSE;
		{combineMode, pulseFunction} <= {1'b0, PI_FREQREF};
		{meas.pulse, upperPct, sleeping, sleepLimitSel} <= {16'd4000, 11'd500, 2'b11};
		{rampSelBit1, rampSelBit2} <= 2'b01;
		tick();
		chk("upperClamp", targetFreq, 6000 * 500 / 1000);
		chk("pidZero", pidLimited, 0);
		chkRamp(2);
		// Auxiliary input on motor two with lower limit
		mainSrcSel <= SRC_AI2AUX;
		{ai2Function, meas.ai2Pct} <= {AI2_AUX, 16'd250};
		{upperPct, lowerPct, motorTwo, sleepLimitSel} <= {PCT_MAX, 11'd300, 2'b10};
		{starting, rampSelUsed, outFreq} <= {2'b10, 16'd5000};
		tick();
		chk("lowerClamp", targetFreq, 8000 * 300 / 1000);
		chk("pidLower", pidLimited, 8000 * 300 / 1000);
		chk("startMin", startFromMin, 1);
		chk("startFreq", startFreq, 150);
		chkRamp(3);
		$display("test source selection done");
		// Serial reference with clipping
		mainSrcSel <= SRC_COMM;
		{motorTwo, lowerPct, starting} <= {1'b0, 11'h000, 1'b0};
		{sleeping, outFreq} <= {1'b0, 16'd1000};
		far.mbWrite(16'd65000);
		cyc(3);
		chk("commClip", commFreqView, FREQ_MAX_CODE);
		far.mbWrite(16'd1234);
		tick();
		chk("commView", commFreqView, 1234);
		chk("commRef", targetFreq, 1234);
		chkRamp(0);
		// Up/down reference stepping
		mainSrcSel <= SRC_UPDN;
		{upDownAssigned, termUp} <= 2'b11;
		{rampSelUsed, rampSelBit1, rampSelBit2} <= 3'b111;
		tick();
		t0 = targetFreq;
		cyc(2 * TICK_CYC);
		chk("upStep", targetFreq, t0 + 2 * UPDN_STEP);
		chkRamp(3);
		$display("test serial and up/down done");
		results();
	end
endmodule : dfrs_select_tb_top
`default_nettype wire
